/* rtl/tctl_setup_reg.sv */
// Trace setup register and companion auxiliary register
`timescale 1ns/1ps
`default_nettype none
`include "tctl_consts.svh"
module tctl_setup_reg
  import tctl_pkg::*;
#(
  parameter bit HAS_TRACE = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [4:0] cop_reg,
  input wire logic [2:0] cop_sel,
  input wire logic cop_wr,
  input wire logic [31:0] cop_wdata,
  output logic [31:0] cop_rdata,
  input wire tctl_ctrl_s hw_ctrl,
  input wire tctl_aux_s hw_aux,
  input wire tctl_mode_e cpu_mode,
  input wire logic instr_valid,
  output logic trace_active,
  output tctl_sel_s trace_sel,
  output logic trace_all_branch,
  output logic trace_inh_ovf
);
  logic src_ff;
  logic on_ff;
  logic [3:0] men_ff;
  logic [2:0] kind_ff;
  logic utype_ff;
  logic allbr_ff;
  logic inhovf_ff;
  logic [31:0] rdata_ff;
  logic act_ff;
  tctl_sel_s sel_ff;
  tctl_ctrl_s eff;
  tctl_sel_s nxt_sel;
  logic nxt_act;
  logic [31:0] nxt_rdata;
  logic mode_ok;
  logic wr_setup;
  logic hit_setup;
  logic hit_aux;

  // Register number and select match, shared by write, read and checks
  function automatic logic tctl_reg_hit(input logic [4:0] num, input logic [2:0] sel, input logic [2:0] want);
    return (num == `TCTL_REG_NUM) && (sel == want);
  endfunction : tctl_reg_hit

  // Address decode
  assign hit_setup = tctl_reg_hit(cop_reg, cop_sel, `TCTL_SEL_SETUP);
  assign hit_aux = tctl_reg_hit(cop_reg, cop_sel, `TCTL_SEL_AUX);
  assign wr_setup = cop_wr && hit_setup;

  // Master enable and source select, reset to zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      on_ff <= `TCTL_RST_ON;
      src_ff <= `TCTL_RST_SRC;
    end else if (wr_setup) begin
      on_ff <= cop_wdata[`TCTL_ON_BIT];
      src_ff <= cop_wdata[`TCTL_SRC_BIT];
    end
  end

  // Kind and mode enables, undefined at reset; zero chosen
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      kind_ff <= `TCTL_RST_KIND;
      men_ff <= `TCTL_RST_ENABLES;
      utype_ff <= 1'b0;
      allbr_ff <= 1'b0;
      inhovf_ff <= 1'b0;
    end else if (wr_setup) begin
      kind_ff <= cop_wdata[`TCTL_KIND_HI:`TCTL_KIND_LO];
      men_ff <= {cop_wdata[`TCTL_DBG_BIT], cop_wdata[`TCTL_EXC_BIT],
                 cop_wdata[`TCTL_KERN_BIT], cop_wdata[`TCTL_USER_BIT]};
      utype_ff <= cop_wdata[`TCTL_USER_TYPE_BIT];
      allbr_ff <= cop_wdata[`TCTL_ALLBR_BIT];
      inhovf_ff <= cop_wdata[`TCTL_INHOVF_BIT];
    end
  end

  // Effective control: software bits or external block
  always_comb begin
    if (src_ff) begin
      eff.on = on_ff;
      eff.dbg_en = men_ff[3];
      eff.exc_en = men_ff[2];
      eff.kern_en = men_ff[1];
      eff.user_en = men_ff[0];
      eff.kind = kind_ff;
    end else begin
      eff = hw_ctrl;
    end
  end

  // Per-mode gate
  always_comb begin
    unique case (cpu_mode)
      TCTL_MODE_USER: mode_ok = eff.user_en;
      TCTL_MODE_KERN: mode_ok = eff.kern_en;
      TCTL_MODE_EXC: mode_ok = eff.exc_en;
      TCTL_MODE_DBG: mode_ok = eff.dbg_en;
    endcase
  end

  assign nxt_act = eff.on && mode_ok && instr_valid;

  tctl_kind_dec u_dec (
    .kind(eff.kind),
    .sel(nxt_sel)
  );

  // Registered trace outputs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      act_ff <= 1'b0;
      sel_ff <= '0;
    end else begin
      act_ff <= nxt_act;
      sel_ff <= nxt_act ? nxt_sel : '0;
    end
  end

  // Read mux
  always_comb begin
    nxt_rdata = 32'h0;
    if (hit_setup) begin
      nxt_rdata[`TCTL_SRC_BIT] = src_ff;
      nxt_rdata[`TCTL_USER_TYPE_BIT] = utype_ff;
      nxt_rdata[`TCTL_ALLBR_BIT] = allbr_ff;
      nxt_rdata[`TCTL_INHOVF_BIT] = inhovf_ff;
      nxt_rdata[`TCTL_DBG_BIT] = men_ff[3];
      nxt_rdata[`TCTL_EXC_BIT] = men_ff[2];
      nxt_rdata[`TCTL_KERN_BIT] = men_ff[1];
      nxt_rdata[`TCTL_USER_BIT] = men_ff[0];
      nxt_rdata[`TCTL_GLOBAL_BIT] = 1'b1;
      nxt_rdata[`TCTL_KIND_HI:`TCTL_KIND_LO] = kind_ff;
      nxt_rdata[`TCTL_ON_BIT] = on_ff;
      // Bits 20:5 stay zero, id fields absent
    end else if (HAS_TRACE && hit_aux) begin
      nxt_rdata[`TCTL_AUX_KINDS_HI:`TCTL_AUX_KINDS_LO] = hw_aux.kinds;
      nxt_rdata[4] = hw_aux.buf_both;
      nxt_rdata[3] = hw_aux.buf_sel;
      nxt_rdata[2:0] = hw_aux.sync_per;
    end
  end

  // Read data register, one cycle behind the address
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs straight from flops
  assign cop_rdata = rdata_ff;
  assign trace_active = act_ff;
  assign trace_sel = sel_ff;
  assign trace_all_branch = allbr_ff;
  assign trace_inh_ovf = inhovf_ff;

  // Assertions
  property p_id_zero;
    @(posedge sys_clk) disable iff (!rstn)
      $past(cop_reg == `TCTL_REG_NUM && cop_sel == `TCTL_SEL_SETUP) |-> cop_rdata[12:5] == 8'h0;
  endproperty
  a_id_zero: assert property (p_id_zero) else $error("id field not zero");

  property p_global_one;
    @(posedge sys_clk) disable iff (!rstn)
      $past(rstn) && $past(hit_setup) |-> cop_rdata[4];
  endproperty
  a_global_one: assert property (p_global_one) else $error("global bit not one");

  property p_kind_rw;
    @(posedge sys_clk) disable iff (!rstn)
      wr_setup ##1 (cop_reg == `TCTL_REG_NUM && cop_sel == `TCTL_SEL_SETUP && !cop_wr)
        |=> cop_rdata[3:1] == $past(cop_wdata[3:1], 2);
  endproperty
  a_kind_rw: assert property (p_kind_rw) else $error("kind readback wrong");

  property p_kind_low;
    @(posedge sys_clk) disable iff (!rstn)
      nxt_act && eff.kind == 3'h3 |=> trace_sel.ld_addr && trace_sel.st_addr && !trace_sel.ld_data;
  endproperty
  a_kind_low: assert property (p_kind_low) else $error("kind 011 decode wrong");

  property p_kind_high;
    @(posedge sys_clk) disable iff (!rstn)
      nxt_act && eff.kind == 3'h4 |=> trace_sel.ld_data && !trace_sel.ld_addr && !trace_sel.st_data;
  endproperty
  a_kind_high: assert property (p_kind_high) else $error("kind 100 decode wrong");

  property p_off_idle;
    @(posedge sys_clk) disable iff (!rstn)
      !eff.on |=> !trace_active && trace_sel == '0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("trace while off");

  property p_mode_gate;
    @(posedge sys_clk) disable iff (!rstn)
      trace_active |-> $past(mode_ok && instr_valid);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("trace without enable");

  property p_user_gate;
    @(posedge sys_clk) disable iff (!rstn)
      src_ff && cpu_mode == TCTL_MODE_USER && !men_ff[0] |=> !trace_active;
  endproperty
  a_user_gate: assert property (p_user_gate) else $error("user trace not gated");

  property p_aux_kinds;
    @(posedge sys_clk) disable iff (!rstn)
      HAS_TRACE && hit_aux |=> cop_rdata[6:5] == $past(hw_aux.kinds);
  endproperty
  a_aux_kinds: assert property (p_aux_kinds) else $error("aux kinds wrong");

  property p_src_hw;
    @(posedge sys_clk) disable iff (!rstn)
      !src_ff && !hw_ctrl.on |=> !trace_active;
  endproperty
  a_src_hw: assert property (p_src_hw) else $error("hw source ignored");

  c_sw_trace: cover property (@(posedge sys_clk) disable iff (!rstn) src_ff && trace_active);
  c_hw_trace: cover property (@(posedge sys_clk) disable iff (!rstn) !src_ff && trace_active);
  c_full_kind: cover property (@(posedge sys_clk) disable iff (!rstn) trace_sel.st_data && trace_sel.ld_data);
endmodule : tctl_setup_reg
`default_nettype wire

/* rtl/tctl_consts.svh */
// Trace setup register constants: field positions, reset values, selects
`ifndef TCTL_CONSTS_SVH
`define TCTL_CONSTS_SVH
`define TCTL_SEL_SETUP 3'h1
`define TCTL_SEL_AUX 3'h2
`define TCTL_REG_NUM 5'h17
`define TCTL_SRC_BIT 31
`define TCTL_USER_TYPE_BIT 30
`define TCTL_ALLBR_BIT 27
`define TCTL_INHOVF_BIT 26
`define TCTL_DBG_BIT 25
`define TCTL_EXC_BIT 24
`define TCTL_KERN_BIT 23
`define TCTL_USER_BIT 21
`define TCTL_GLOBAL_BIT 4
`define TCTL_KIND_HI 3
`define TCTL_KIND_LO 1
`define TCTL_ON_BIT 0
`define TCTL_AUX_KINDS_HI 6
`define TCTL_AUX_KINDS_LO 5
`define TCTL_RST_ON 1'h0
`define TCTL_RST_SRC 1'h0
`define TCTL_RST_KIND 3'h0
`define TCTL_RST_ENABLES 4'h0
`endif

/* rtl/tctl_pkg.sv */
// Trace setup register types
package tctl_pkg;
  typedef enum logic [1:0] {
    TCTL_MODE_USER = 2'h0,
    TCTL_MODE_KERN = 2'h1,
    TCTL_MODE_EXC = 2'h3,
    TCTL_MODE_DBG = 2'h2
  } tctl_mode_e;
  typedef struct packed {
    logic pc;
    logic ld_addr;
    logic st_addr;
    logic ld_data;
    logic st_data;
  } tctl_sel_s;
  typedef struct packed {
    logic on;
    logic user_en;
    logic kern_en;
    logic exc_en;
    logic dbg_en;
    logic [2:0] kind;
  } tctl_ctrl_s;
  typedef struct packed {
    logic [1:0] kinds;
    logic buf_both;
    logic buf_sel;
    logic [2:0] sync_per;
  } tctl_aux_s;
endpackage : tctl_pkg

/* rtl/tctl_kind_dec.sv */
// Trace kind decoder: kind code to traced item set
`timescale 1ns/1ps
`default_nettype none
module tctl_kind_dec
  import tctl_pkg::*;
(
  input wire logic [2:0] kind,
  output tctl_sel_s sel
);
  // Bit 2 adds data, bits 1:0 pick loads/stores
  always_comb begin
    sel.pc = 1'b1;
    sel.ld_addr = (kind == 3'h1) | (kind == 3'h3) | (kind == 3'h5) | (kind == 3'h7);
    sel.st_addr = (kind == 3'h2) | (kind == 3'h3) | (kind == 3'h6) | (kind == 3'h7);
    sel.ld_data = (kind == 3'h4) | (kind == 3'h5) | (kind == 3'h7);
    sel.st_data = (kind == 3'h6) | (kind == 3'h7);
  end
endmodule : tctl_kind_dec
`default_nettype wire

/* bench/tctl_ext_model.sv */
// Model of the external trace block: hardware control and status feed
`timescale 1ns/1ps
`default_nettype none
module tctl_ext_model
  import tctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hw_on,
  output var tctl_ctrl_s hw_ctrl,
  output var tctl_aux_s hw_aux
);
  // Status holds junk in reset, valid values once the block runs
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hw_aux <= 7'h2a;
    end else begin
      hw_aux <= 7'h55;
    end
  end
  // Hardware control: user tracing, supported kind 001 only
  assign hw_ctrl = hw_on ? 8'hc1 : 8'h00;
endmodule : tctl_ext_model
`default_nettype wire

/* bench/tb.sv */
// Self-checking bench for the trace setup register
`timescale 1ns/1ps
`default_nettype none
module tb
  import tctl_pkg::*;
;
  typedef struct packed {logic [31:0] wd; tctl_mode_e md; logic [5:0] exp;} tctl_row_s;
  logic sys_clk, rstn, cop_wr, instr_valid, hw_on, trace_active, trace_all_branch, trace_inh_ovf;
  logic [4:0] cop_reg;
  logic [2:0] cop_sel;
  logic [31:0] cop_wdata, cop_rdata;
  tctl_ctrl_s hw_ctrl;
  tctl_aux_s hw_aux;
  tctl_mode_e cpu_mode;
  tctl_sel_s trace_sel;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  // Written word, mode, then expected {active, pc, ld_a, st_a, ld_d, st_d}
  tctl_row_s rows [0:10] = '{
    '{32'h8020_0001, TCTL_MODE_USER, 6'h30}, '{32'h8020_0003, TCTL_MODE_USER, 6'h38},
    '{32'h8080_0005, TCTL_MODE_KERN, 6'h34}, '{32'h8100_0007, TCTL_MODE_EXC, 6'h3c},
    '{32'h8200_0009, TCTL_MODE_DBG, 6'h32}, '{32'h8020_000b, TCTL_MODE_USER, 6'h3a},
    '{32'h8020_000d, TCTL_MODE_USER, 6'h35}, '{32'hffff_ffff, TCTL_MODE_USER, 6'h3f},
    '{32'h8020_000e, TCTL_MODE_USER, 6'h00}, '{32'h8080_0003, TCTL_MODE_USER, 6'h00},
    '{32'h0020_0003, TCTL_MODE_USER, 6'h00}};
  tctl_setup_reg #(.HAS_TRACE(1'h1)) dut (.sys_clk(sys_clk), .rstn(rstn), .cop_reg(cop_reg),
    .cop_sel(cop_sel), .cop_wr(cop_wr), .cop_wdata(cop_wdata), .cop_rdata(cop_rdata),
    .hw_ctrl(hw_ctrl), .hw_aux(hw_aux), .cpu_mode(cpu_mode), .instr_valid(instr_valid),
    .trace_active(trace_active), .trace_sel(trace_sel), .trace_all_branch(trace_all_branch),
    .trace_inh_ovf(trace_inh_ovf));
  tctl_ext_model ext (.sys_clk(sys_clk), .rstn(rstn), .hw_on(hw_on), .hw_ctrl(hw_ctrl), .hw_aux(hw_aux));
  // Clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    cop_sel = s;
    cop_wdata = d;
    cop_wr = 1'h1;
    @(negedge sys_clk);
    cop_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] s, input logic [31:0] exp);
    cop_sel = s;
    @(negedge sys_clk);
    chk(cop_rdata, exp);
  endtask : rd
  task automatic trc(input tctl_mode_e m, input logic [5:0] exp);
    cpu_mode = m;
    instr_valid = 1'h1;
    @(negedge sys_clk);
    chk({26'h0, trace_active, trace_sel}, {26'h0, exp});
    instr_valid = 1'h0;
    @(negedge sys_clk);
  endtask : trc
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Reset, table of kinds and modes, then the awkward cases
  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    cop_reg = 5'h17;
    cop_sel = 3'h1;
    cop_wr = 1'h0;
    cop_wdata = 32'h0;
    cpu_mode = TCTL_MODE_USER;
    instr_valid = 1'h0;
    hw_on = 1'h0;
    repeat (6) @(negedge sys_clk);
    chk(cop_rdata, 32'h0);
    rstn = 1'h1;
    rd(3'h1, 32'h0000_0010);
    trc(TCTL_MODE_USER, 6'h00);
    foreach (rows[i]) begin
      wr(3'h1, rows[i].wd);
      rd(3'h1, (rows[i].wd & 32'hcfa0_000f) | 32'h10);
      chk({30'h0, trace_all_branch, trace_inh_ovf}, {30'h0, rows[i].wd[27:26]});
      trc(rows[i].md, rows[i].exp);
    end
    rd(3'h2, 32'h0000_0055);
    wr(3'h2, 32'hffff_ffff);
    rd(3'h2, 32'h0000_0055);
    cop_reg = 5'h16;
    wr(3'h1, 32'hffff_ffff);
    rd(3'h1, 32'h0);
    cop_reg = 5'h17;
    rd(3'h1, 32'h0020_0013);
    hw_on = 1'h1;
    trc(TCTL_MODE_USER, 6'h38);
    trc(TCTL_MODE_KERN, 6'h00);
    rstn = 1'h0;
    @(negedge sys_clk);
    chk({cop_rdata[30:0], trace_active}, 32'h0);
    chk({27'h0, trace_sel}, 32'h0);
    rstn = 1'h1;
    hw_on = 1'h0;
    rd(3'h1, 32'h0000_0010);
    stop_test();
  end
endmodule : tb
`default_nettype wire
